// file: src/tx_timer_pkg.sv
/*
 * Constants, types and register map for the transmit keying and timer controller.
 * Assumes a 100 MHz pclk and a 32-bit APB master.
 */
package tx_timer_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 10;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_NS;
    localparam int TAIL_STEP_MS = 100;
    localparam int TAIL_STEP_EXT_MS = 20;
    localparam int TAIL_MAX_MS = 5000;
    localparam int LONG_STEP_S = 10;
    localparam int TOUT_MAX_S = 300;
    localparam int TOUT_MAX_EXT_S = 600;
    localparam int LOCK_MAX_S = 60;
    localparam int OSC_HOLD_MS = 50;
    localparam logic [15:0] TAIL_TICKS = 16'(TAIL_STEP_MS / TICK_MS);
    localparam logic [15:0] TAIL_TICKS_EXT = 16'(TAIL_STEP_EXT_MS / TICK_MS);
    localparam logic [15:0] LONG_TICKS = 16'(LONG_STEP_S * 1000 / TICK_MS);
    localparam logic [15:0] OSC_HOLD_TICKS = 16'(OSC_HOLD_MS / TICK_MS);
    localparam logic [7:0] TAIL_MAX_STEPS = 8'(TAIL_MAX_MS / TAIL_STEP_MS);
    localparam logic [7:0] TAIL_MAX_STEPS_EXT = 8'(TAIL_MAX_MS / TAIL_STEP_EXT_MS);
    localparam logic [7:0] TOUT_MAX_STEPS = 8'(TOUT_MAX_S / LONG_STEP_S);
    localparam logic [7:0] TOUT_MAX_STEPS_EXT = 8'(TOUT_MAX_EXT_S / LONG_STEP_S);
    localparam logic [7:0] LOCK_MAX_STEPS = 8'(LOCK_MAX_S / LONG_STEP_S);

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_TAIL = 12'h004;
    localparam logic [11:0] ADDR_TOUT = 12'h008;
    localparam logic [11:0] ADDR_LOCK = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_INT_STAT = 12'h014;
    localparam logic [11:0] ADDR_INT_MASK = 12'h018;
    localparam int CTRL_EXT_BIT = 0;
    localparam int NUM_EVENTS = 5;
    localparam int EV_KEY_START = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_LOCK_END = 2;
    localparam int EV_UNLOCK = 3;
    localparam int EV_TAIL_END = 4;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_KEYED = 5'h02,
        ST_TAIL = 5'h04,
        ST_LOCKOUT = 5'h08,
        ST_WAIT_REL = 5'h10
    } state_type;

    typedef struct packed {
        logic unlock;
        logic opto;
        logic ptt;
        logic carrier;
        logic ext_key;
    } pin_in_type;

endpackage

// file: src/tx_key_timer.sv
/*
 * Transmit keying and timer controller: key source merge, tail, timeout,
 * lockout, supply sequencing and lock gating, with an APB register slave.
 * Assumes all pin inputs are asynchronous to pclk and an APB master on pclk.
 */
// Implementation choices: the placing of the registers and the APB register port.
// What this block does
// RULE1: a low external key request line requests transmission.
// RULE2: carrier button keys the transmitter and mutes all audio while it keys.
// RULE3: microphone push-to-talk keys and disables line audio, leaving microphone only.
// RULE4: the isolated opto-key input keys like any other source.
// RULE5: after all keys drop, stay transmitting for tail of 0-5 s, 100 ms steps.
// RULE6: timeout of 0-300 s in 10 s steps stops transmit; needs fresh key.
// RULE7: after timeout refuse keying for lockout of 0-60 s in 10 s steps.
// RULE8: extended mode gives 20 ms tail steps and 600 s timeout ceiling.
// RULE9: transmit supply is switched only by the derived transmit enable.
// RULE10: out of lock inhibits power control and RF drive even while keyed.
// RULE11: loss of lock cuts the drive amplifier supply.
// RULE12: oscillator supply stays on for a short hold after transmit supply drops.
// RULE13: key request is OR of four sources; rekey during tail cancels tail.
// RULE14: a timer value of zero disables that timer.
`timescale 1ns/1ps
module tx_key_timer #(
    parameter int TICK_CYCLES = tx_timer_pkg::TICK_CYCLES
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic ext_key_n, // rear key request, low keys
    input wire logic carrier_btn, // front carrier-only button
    input wire logic mic_ptt, // microphone push-to-talk
    input wire logic opto_key, // isolated opto-key input
    input wire logic synth_unlock, // lock indicator, high out of lock
    output logic tx_reg_en, // transmit regulator supply switch
    output logic osc_supply_en, // oscillator supply
    output logic drive_supply_en, // drive amplifier supply
    output logic power_ctrl_en, // power control enable
    output logic rf_drive_en, // rf switch at drive amplifier input
    output logic audio_mute, // mute every audio path
    output logic line_audio_dis, // disable line audio input
    output logic irq // interrupt, high while unmasked event pending
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam int TW = $clog2(TICK_CYCLES + 1);
    tx_timer_pkg::pin_in_type s1_ff, s2_ff, s3_ff, pins_ff;
    tx_timer_pkg::state_type state_ff;
    logic [TW-1:0] tick_cnt_ff;
    logic tick_ff;
    logic [15:0] tmr_ff, tout_ff, osc_cnt_ff;
    logic [7:0] tail_cfg_ff, tout_cfg_ff, lock_cfg_ff;
    logic ext_mode_ff, unlock_d_ff;
    logic [tx_timer_pkg::NUM_EVENTS-1:0] int_stat_ff, int_mask_ff, nxt_int_stat, ev;
    logic [15:0] tail_ticks, tout_ticks, lock_ticks;
    logic key_any, tx_on, tout_hit, unlock_s;
    logic wr_en, setup, mapped;
    logic [31:0] rd_val;

    function automatic logic [7:0] clamp(input logic [31:0] v, input logic [7:0] lim);
        clamp = (v > 32'(lim)) ? lim : v[7:0];
    endfunction

    function automatic logic [15:0] scale(input logic [7:0] steps, input logic [15:0] unit);
        logic [23:0] p;
        p = 24'(steps) * 24'(unit);
        scale = p[15:0];
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // a bit changes only when the second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            pins_ff <= '0;
        end else begin
            // RULE1: rear line keys when low
            s1_ff <= {synth_unlock, opto_key, mic_ptt, carrier_btn, ~ext_key_n};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pins_ff <= (s2_ff & s3_ff) | (pins_ff & (s2_ff ^ s3_ff));
        end
    end

    // RULE13: or of four sources
    // RULE4: opto key joins the merge
    assign key_any = pins_ff.ext_key | pins_ff.carrier | pins_ff.ptt | pins_ff.opto;
    assign unlock_s = pins_ff.unlock;
    assign tx_on = (state_ff == tx_timer_pkg::ST_KEYED) || (state_ff == tx_timer_pkg::ST_TAIL);

    // ----------------------------------------
    // tick prescaler
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1));
            tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_ff + 1'b1;
        end
    end

    // ----------------------------------------
    // timer limits
    // ----------------------------------------
    // RULE8: extended mode shortens tail steps
    assign tail_ticks = scale(tail_cfg_ff, ext_mode_ff ? tx_timer_pkg::TAIL_TICKS_EXT : tx_timer_pkg::TAIL_TICKS);
    assign tout_ticks = scale(tout_cfg_ff, tx_timer_pkg::LONG_TICKS);
    assign lock_ticks = scale(lock_cfg_ff, tx_timer_pkg::LONG_TICKS);
    // RULE14: zero disables the timeout
    assign tout_hit = (tout_cfg_ff != '0) && (tout_ff >= tout_ticks);

    // ----------------------------------------
    // keying sequencer
    // ----------------------------------------
    // the timeout counter keeps running through the tail, so a rekeyed tail
    // cannot be used to stretch one transmission past the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= tx_timer_pkg::ST_IDLE;
            tmr_ff <= '0;
            tout_ff <= '0;
        end else begin
            if (tick_ff && tx_on && !tout_hit)
                tout_ff <= tout_ff + 1'b1;
            if (tick_ff && (state_ff == tx_timer_pkg::ST_TAIL || state_ff == tx_timer_pkg::ST_LOCKOUT))
                tmr_ff <= tmr_ff + 1'b1;
            case (state_ff)
                tx_timer_pkg::ST_IDLE: begin
                    tout_ff <= '0;
                    if (key_any)
                        state_ff <= tx_timer_pkg::ST_KEYED;
                end
                tx_timer_pkg::ST_KEYED, tx_timer_pkg::ST_TAIL: begin
                    if (tout_hit) begin
                        // RULE6: timeout ends transmission
                        // RULE7: lockout only when programmed
                        tmr_ff <= '0;
                        state_ff <= (lock_cfg_ff != '0) ? tx_timer_pkg::ST_LOCKOUT : tx_timer_pkg::ST_WAIT_REL;
                    end else if (key_any) begin
                        // RULE13: rekey cancels the tail
                        tmr_ff <= '0;
                        state_ff <= tx_timer_pkg::ST_KEYED;
                    end else if (state_ff == tx_timer_pkg::ST_KEYED) begin
                        // RULE5: start tail hold
                        // RULE14: zero tail drops at once
                        tmr_ff <= '0;
                        state_ff <= (tail_cfg_ff != '0) ? tx_timer_pkg::ST_TAIL : tx_timer_pkg::ST_IDLE;
                    end else if (tmr_ff >= tail_ticks) begin
                        state_ff <= tx_timer_pkg::ST_IDLE;
                    end
                end
                tx_timer_pkg::ST_LOCKOUT: begin
                    // RULE7: refuse keying until elapsed
                    if (tmr_ff >= lock_ticks)
                        state_ff <= tx_timer_pkg::ST_WAIT_REL;
                end
                tx_timer_pkg::ST_WAIT_REL: begin
                    // RULE6: fresh key needed
                    if (!key_any)
                        state_ff <= tx_timer_pkg::ST_IDLE;
                end
                default: state_ff <= tx_timer_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // supply and rf outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_reg_en <= 1'b0;
            drive_supply_en <= 1'b0;
            power_ctrl_en <= 1'b0;
            rf_drive_en <= 1'b0;
            audio_mute <= 1'b0;
            line_audio_dis <= 1'b0;
        end else begin
            // RULE9: supply follows the keying logic only
            tx_reg_en <= tx_on;
            // RULE10: lock gates power control and rf
            // RULE11: unlock cuts drive supply
            drive_supply_en <= tx_on && !unlock_s;
            power_ctrl_en <= tx_on && !unlock_s;
            rf_drive_en <= tx_on && !unlock_s;
            // RULE2: carrier mutes all audio
            audio_mute <= tx_on && pins_ff.carrier;
            // RULE3: ptt drops line audio
            line_audio_dis <= pins_ff.ptt;
        end
    end

    // RULE12: oscillator hold after supply off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_ff <= '0;
            osc_supply_en <= 1'b0;
        end else begin
            if (tx_on)
                osc_cnt_ff <= tx_timer_pkg::OSC_HOLD_TICKS;
            else if (tick_ff && osc_cnt_ff != '0)
                osc_cnt_ff <= osc_cnt_ff - 1'b1;
            osc_supply_en <= tx_on || (osc_cnt_ff != '0);
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // zero wait state: ready in the first access cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign mapped = (paddr <= tx_timer_pkg::ADDR_INT_MASK) && (paddr[1:0] == 2'h0);

    always_comb begin
        rd_val = '0;
        case (paddr)
            tx_timer_pkg::ADDR_CTRL: rd_val[tx_timer_pkg::CTRL_EXT_BIT] = ext_mode_ff;
            tx_timer_pkg::ADDR_TAIL: rd_val[7:0] = tail_cfg_ff;
            tx_timer_pkg::ADDR_TOUT: rd_val[7:0] = tout_cfg_ff;
            tx_timer_pkg::ADDR_LOCK: rd_val[7:0] = lock_cfg_ff;
            tx_timer_pkg::ADDR_STATUS: rd_val[15:0] = {6'h00, state_ff, pins_ff};
            tx_timer_pkg::ADDR_INT_STAT: rd_val[tx_timer_pkg::NUM_EVENTS-1:0] = int_stat_ff;
            tx_timer_pkg::ADDR_INT_MASK: rd_val[tx_timer_pkg::NUM_EVENTS-1:0] = int_mask_ff;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= setup ? rd_val : '0;
        end
    end

    // limits are applied on write so readback shows the value in force
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_mode_ff <= 1'b0;
            tail_cfg_ff <= '0;
            tout_cfg_ff <= '0;
            lock_cfg_ff <= '0;
            int_mask_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                // RULE8: extended mode select
                tx_timer_pkg::ADDR_CTRL: ext_mode_ff <= pwdata[tx_timer_pkg::CTRL_EXT_BIT];
                tx_timer_pkg::ADDR_TAIL: tail_cfg_ff <= clamp(pwdata,
                    ext_mode_ff ? tx_timer_pkg::TAIL_MAX_STEPS_EXT : tx_timer_pkg::TAIL_MAX_STEPS);
                tx_timer_pkg::ADDR_TOUT: tout_cfg_ff <= clamp(pwdata,
                    ext_mode_ff ? tx_timer_pkg::TOUT_MAX_STEPS_EXT : tx_timer_pkg::TOUT_MAX_STEPS);
                tx_timer_pkg::ADDR_LOCK: lock_cfg_ff <= clamp(pwdata, tx_timer_pkg::LOCK_MAX_STEPS);
                tx_timer_pkg::ADDR_INT_MASK: int_mask_ff <= pwdata[tx_timer_pkg::NUM_EVENTS-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always_comb begin
        ev = '0;
        ev[tx_timer_pkg::EV_KEY_START] = (state_ff == tx_timer_pkg::ST_IDLE) && key_any;
        ev[tx_timer_pkg::EV_TIMEOUT] = tx_on && tout_hit;
        ev[tx_timer_pkg::EV_LOCK_END] = (state_ff == tx_timer_pkg::ST_LOCKOUT) && (tmr_ff >= lock_ticks);
        ev[tx_timer_pkg::EV_UNLOCK] = unlock_s && !unlock_d_ff;
        ev[tx_timer_pkg::EV_TAIL_END] = (state_ff == tx_timer_pkg::ST_TAIL) && !key_any && !tout_hit
            && (tmr_ff >= tail_ticks);
        // a new event wins over a clear in the same cycle
        nxt_int_stat = int_stat_ff;
        if (wr_en && paddr == tx_timer_pkg::ADDR_INT_STAT)
            nxt_int_stat = nxt_int_stat & ~pwdata[tx_timer_pkg::NUM_EVENTS-1:0];
        nxt_int_stat = nxt_int_stat | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_ff <= '0;
            unlock_d_ff <= 1'b0;
            irq <= 1'b0;
        end else begin
            int_stat_ff <= nxt_int_stat;
            unlock_d_ff <= unlock_s;
            irq <= |(nxt_int_stat & int_mask_ff);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_keyed_release;
        state_ff == tx_timer_pkg::ST_KEYED && !key_any && !tout_hit;
    endsequence

    sequence s_timeout;
        tx_on && tout_hit;
    endsequence

    a_key_starts_tx: assert property ((state_ff == tx_timer_pkg::ST_IDLE && pins_ff.ext_key) |=> tx_on) // RULE1
        else $error("external key did not start transmission");
    a_carrier_mutes: assert property ((tx_on && pins_ff.carrier) |=> audio_mute) // RULE2
        else $error("carrier key left audio on");
    a_ptt_line_off: assert property (pins_ff.ptt |=> line_audio_dis) // RULE3
        else $error("ptt left line audio enabled");
    a_opto_keys: assert property ((state_ff == tx_timer_pkg::ST_IDLE && pins_ff.opto) |=> ##1 tx_reg_en) // RULE4
        else $error("opto key did not raise transmit supply");
    a_tail_entry: assert property ((s_keyed_release and tail_cfg_ff != '0) |=> state_ff == tx_timer_pkg::ST_TAIL) // RULE5
        else $error("tail not entered on release");
    a_timeout_stops: assert property (s_timeout |=> !tx_on ##1 !tx_reg_en) // RULE6
        else $error("timeout did not stop transmission");
    a_lockout_holds: assert property (state_ff == tx_timer_pkg::ST_LOCKOUT |=> !tx_on) // RULE7
        else $error("keyed during lockout");
    a_ext_tail_unit: assert property ((ext_mode_ff && tail_cfg_ff == 8'h02) |-> tail_ticks == 16'h0004) // RULE8
        else $error("extended tail step wrong");
    a_supply_follows: assert property ($rose(tx_reg_en) |-> $past(tx_on)) // RULE9
        else $error("supply raised without keying");
    a_unlock_cuts_rf: assert property (unlock_s |=> !rf_drive_en && !power_ctrl_en) // RULE10
        else $error("rf on while out of lock");
    a_unlock_drive: assert property (unlock_s |=> !drive_supply_en) // RULE11
        else $error("drive supply on while out of lock");
    a_osc_hold: assert property ($fell(tx_reg_en) |-> osc_supply_en [*2]) // RULE12
        else $error("oscillator dropped with transmit supply");
    a_rekey_tail: assert property ((state_ff == tx_timer_pkg::ST_TAIL && key_any && !tout_hit) |=> state_ff == tx_timer_pkg::ST_KEYED) // RULE13
        else $error("rekey did not cancel tail");
    a_zero_tail: assert property ((s_keyed_release and tail_cfg_ff == '0) |=> state_ff == tx_timer_pkg::ST_IDLE) // RULE14
        else $error("zero tail still held");

endmodule

// file: verification/key_sources.sv
/*
 * Model of the keying switches, opto-coupler and lock detector feeding the block.
 * Assumes the bench sets the wanted levels in req just after a pclk edge.
 */
`timescale 1ns/1ps
module key_sources (
    input wire logic pclk, // bench clock
    input wire tx_timer_pkg::pin_in_type req, // wanted source levels, high active
    output logic ext_key_n, // rear key line, pulled low to key
    output logic carrier_btn, // front carrier button
    output logic mic_ptt, // microphone push-to-talk
    output logic opto_key, // opto-coupler output
    output logic synth_unlock // lock detector, high out of lock
);
    // switches change on the pclk edge after req is set; one flop of delay is harmless
    always @(posedge pclk) begin
        ext_key_n <= ~req.ext_key;
        carrier_btn <= req.carrier;
        mic_ptt <= req.ptt;
        opto_key <= req.opto;
        synth_unlock <= req.unlock;
    end
endmodule

// file: verification/tb_top.sv
/*
 * Self-checking bench for the transmit key timer: APB tasks plus key scenarios.
 * Assumes TICK_CYCLES of 4, so one 10 ms tick lasts 4 pclk cycles.
 */
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, ek_n, cb, ptt, opto, unl;
    logic tx, osc, drv, pwr, rf, mute, ldis, irq;
    tx_timer_pkg::pin_in_type req = '0;
    int fails = 0, compares = 0, cyc = 0, n, i;

    always #5 pclk = ~pclk;
    key_sources ks (.pclk(pclk), .req(req), .ext_key_n(ek_n), .carrier_btn(cb), .mic_ptt(ptt),
        .opto_key(opto), .synth_unlock(unl));
    tx_key_timer #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_key_n(ek_n), .carrier_btn(cb), .mic_ptt(ptt), .opto_key(opto),
        .synth_unlock(unl), .tx_reg_en(tx), .osc_supply_en(osc), .drive_supply_en(drv),
        .power_ctrl_en(pwr), .rf_drive_en(rf), .audio_mute(mute), .line_audio_dis(ldis), .irq(irq));

    task give_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // the whole run needs about 9000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            give_verdict;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // s=0 watches tx_reg_en, s=1 osc_supply_en; n counts cycles waited
    task waitfor(input int s, input logic v, input int lim);
        n = 0;
        while (n < lim && ((s == 0 ? tx : osc) !== v)) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task keyed(input logic [4:0] k);
        @(posedge pclk);
        req <= k;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        // ----------------------------------------
        // reset values and bus refusal
        // ----------------------------------------
        for (i = 0; i < 7; i++) begin
            apb(0, 12'(i * 4), 0);
            chk(r, i == 4 ? 32'h20 : 0);
        end
        apb(1, 12'h01C, 32'hFF);
        chk({31'h0, e}, 1);
        chk({31'h0, tx}, 0);
        $display("reset test done");
        // each source keys; tail zero drops at once
        for (i = 0; i < 4; i++) begin
            keyed(5'(1 << i));
            waitfor(0, 1, 20);
            chk({tx, mute, ldis}, {1'b1, i == 1, i == 2});
            keyed(0);
            waitfor(0, 0, 20);
            chk(32'(n < 20), 1);
        end
        $display("sources test done");
        // tail of 2 steps: 200 ms, then 40 ms in extended mode
        apb(1, 12'h004, 2);
        for (i = 0; i < 2; i++) begin
            keyed(5'h01);
            waitfor(0, 1, 20);
            keyed(0);
            waitfor(0, 0, 200);
            chk(32'(n >= (i ? 12 : 72) && n <= (i ? 28 : 92)), 1);
            chk({31'h0, osc}, 1);
            waitfor(1, 0, 60);
            chk(32'(n >= 15 && n <= 26), 1);
            apb(1, 12'h000, 1);
            apb(1, 12'h004, 2);
        end
        keyed(5'h01);
        waitfor(0, 1, 20);
        keyed(0);
        repeat (8) @(posedge pclk);
        keyed(5'h08);
        repeat (40) @(posedge pclk);
        chk({31'h0, tx}, 1);
        keyed(0);
        waitfor(0, 0, 60);
        for (i = 0; i < 2; i++) begin
            apb(1, 12'h000, 32'(i));
            apb(1, 12'h004, 32'hFF);
            apb(0, 12'h004, 0);
            chk(r, i ? 32'hFA : 32'h32);
            apb(1, 12'h008, 32'hFF);
            apb(0, 12'h008, 0);
            chk(r, i ? 32'h3C : 32'h1E);
        end
        $display("tail test done");
        // timeout of 10 s, lockout of 10 s, key held throughout
        apb(1, 12'h000, 0);
        apb(1, 12'h004, 0);
        apb(1, 12'h008, 1);
        apb(1, 12'h00C, 32'hFF);
        apb(0, 12'h00C, 0);
        chk(r, 6);
        apb(1, 12'h00C, 1);
        apb(1, 12'h014, 32'h1F);
        keyed(5'h01);
        waitfor(0, 1, 20);
        waitfor(0, 0, 4200);
        chk(32'(n >= 3900), 1);
        apb(0, 12'h010, 0);
        chk(r, 32'h101);
        apb(0, 12'h014, 0);
        chk(r & 32'h2, 2);
        repeat (4100) @(posedge pclk);
        apb(0, 12'h010, 0);
        chk(r, 32'h201);
        chk({31'h0, tx}, 0);
        keyed(0);
        repeat (10) @(posedge pclk);
        keyed(5'h04);
        waitfor(0, 1, 20);
        chk({31'h0, tx}, 1);
        keyed(0);
        waitfor(0, 0, 20);
        $display("timeout test done");
        // lock loss while keyed, with interrupt
        apb(1, 12'h008, 0);
        apb(1, 12'h014, 32'h1F);
        apb(1, 12'h018, 32'h08);
        chk({31'h0, irq}, 0);
        keyed(5'h01);
        waitfor(0, 1, 20);
        chk({rf, drv, pwr}, 3'h7);
        keyed(5'h11);
        repeat (8) @(posedge pclk);
        chk({tx, rf, drv, pwr, irq}, 5'h11);
        apb(1, 12'h018, 0);
        // irq is registered behind the mask, so it settles one edge after the write
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0);
        apb(1, 12'h018, 32'h08);
        apb(1, 12'h014, 32'h08);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0);
        keyed(0);
        waitfor(0, 0, 20);
        $display("lock test done");
        give_verdict;
    end
endmodule
